// file: ucr_pkg.sv
/*
  Constants shared by the UART/CAN raw relay: register map, field layout,
  reset values, limits and timing.
  Assumes a 100 MHz system clock and a synchronous active-high reset.
*/
package ucr_pkg;
  // Clock and indicator timing
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned FLASH_MS       = 100;
  localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_MS / 2;
  localparam int unsigned FLASH_W        = 23;

  // Register bus
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 32;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_CFG    = 4'h1;
  localparam logic [3:0]  REG_STATUS = 4'h2;
  localparam logic [3:0]  REG_COUNT  = 4'h3;

  // Control bits
  localparam int unsigned CTRL_W         = 4;
  localparam int unsigned CTRL_U2C_BIT   = 0;
  localparam int unsigned CTRL_C2U_BIT   = 1;
  localparam int unsigned CTRL_EXT_BIT   = 2;
  localparam int unsigned CTRL_IDOUT_BIT = 3;
  localparam logic [3:0]  CTRL_RST       = 4'h3;

  // Configuration fields
  localparam int unsigned POS_LSB     = 0;
  localparam int unsigned WID_LSB     = 4;
  localparam logic [2:0]  POS_RST     = 3'h0;
  localparam logic [2:0]  WID_RST     = 3'h1;
  localparam logic [2:0]  WID_MAX_STD = 3'h2;
  localparam logic [2:0]  WID_MAX_EXT = 3'h4;

  // Status bits
  localparam int unsigned ST_FAIL  = 0;
  localparam int unsigned ST_TRUNC = 1;
  localparam int unsigned ST_DROP  = 2;
  localparam int unsigned ST_U2C   = 3;
  localparam int unsigned ST_C2U   = 4;

  // Frame and block limits
  localparam logic [28:0] ID_MASK_STD = 29'h00007ff;
  localparam logic [28:0] ID_MASK_EXT = 29'h1fffffff;
  localparam logic [8:0]  BLOCK_MAX   = 9'h100;
  localparam logic [3:0]  FRAME_MAX   = 4'h8;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned FIFO_W      = 9;
endpackage

// file: ucr_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides and registered input ready.
  Assumes one clock and a synchronous active-high reset; DEPTH a power of two.
*/
module ucr_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_clk,       // System clock
  input  wire logic             i_rst,       // Synchronous reset
  input  wire logic             i_in_valid,  // Write request
  input  wire logic [WIDTH-1:0] i_in_data,   // Write data
  output logic                  o_in_ready,  // Room for a word
  output logic                  o_out_valid, // Word available
  output logic      [WIDTH-1:0] o_out_data,  // Oldest word
  input  wire logic             i_out_ready  // Reader takes the word
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    wr_ptr_nxt;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW-1:0]    rd_ptr_nxt;
  logic [CW-1:0]    count_r;
  logic [CW-1:0]    count_nxt;
  logic             rdy_r;
  logic             rdy_nxt;
  logic             push;
  logic             pop;

  // Handshakes and pointer arithmetic
  always_comb
  begin
    push       = i_in_valid && rdy_r;
    pop        = i_out_ready && (count_r != '0);
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    count_nxt  = count_r + CW'(push) - CW'(pop);
    rdy_nxt    = count_nxt != CW'(DEPTH);
  end

  // State registers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      rdy_r    <= 1'b0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
      rdy_r    <= rdy_nxt;
    end
  end

  // Storage, written only on a push
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= i_in_data;
  end

  assign o_in_ready  = rdy_r;
  assign o_out_valid = count_r != '0;
  assign o_out_data  = mem_r[rd_ptr_r];
endmodule

// file: ucr_relay.sv
/*
  UART/CAN raw relay: serial byte blocks become CAN frames, received CAN
  frames become serial bytes. Registers over a plain strobe port.
  Assumes byte streams with valid/ready, a CAN controller taking whole frames,
  one 100 MHz clock and a synchronous active-high reset.
*/
module ucr_relay #(
  parameter int unsigned FLASH_HALF = ucr_pkg::FLASH_HALF_CYC
) (
  input  wire logic                        i_clk,             // System clock
  input  wire logic                        i_rst,             // Synchronous reset
  input  wire logic [ucr_pkg::ADDR_W-1:0]  i_addr,            // Register address
  input  wire logic [ucr_pkg::DATA_W-1:0]  i_wdata,           // Write data
  input  wire logic                        i_wr,              // Write strobe
  input  wire logic                        i_rd,              // Read strobe
  output logic      [ucr_pkg::DATA_W-1:0]  o_rdata,           // Read data, cycle after strobe
  input  wire logic                        i_ser_valid,       // Serial byte in
  input  wire logic [7:0]                  i_ser_data,        // Serial byte value
  input  wire logic                        i_ser_last,        // Last byte of block
  output logic                             o_ser_ready,       // Serial byte accepted
  output logic                             o_tx_valid,        // Serial byte out
  output logic      [7:0]                  o_tx_data,         // Serial byte out value
  input  wire logic                        i_tx_ready,        // Serial sink takes byte
  output logic                             o_can_tx_valid,    // Frame waiting to send
  output logic      [28:0]                 o_can_tx_id,       // Frame identifier
  output logic                             o_can_tx_ext,      // Extended format
  output logic      [3:0]                  o_can_tx_dlc,      // Frame length code
  output logic      [63:0]                 o_can_tx_data,     // Payload, byte 0 low
  input  wire logic                        i_can_tx_ready,    // Controller takes frame
  input  wire logic                        i_can_tx_done,     // Frame sent on bus
  input  wire logic                        i_can_tx_err,      // Frame failed on bus
  input  wire logic                        i_can_rx_valid,    // Frame received
  input  wire logic [28:0]                 i_can_rx_id,       // Received identifier
  input  wire logic                        i_can_rx_ext,      // Received format
  input  wire logic [3:0]                  i_can_rx_dlc,      // Received length code
  input  wire logic [63:0]                 i_can_rx_data,     // Received payload
  output logic                             o_power_indicator  // Power indicator drive
);
  import ucr_pkg::*;

  typedef enum logic {U_COLLECT, U_SEND} ucr_ustate_t;

  // Identifier mask of the selected format
  function automatic logic [28:0] id_mask(input logic ext);
    id_mask = ext ? ID_MASK_EXT : ID_MASK_STD;
  endfunction

  // Identifier field width clamped to the format
  function automatic logic [2:0] eff_width(input logic [2:0] w, input logic ext);
    logic [2:0] lim;
    lim       = ext ? WID_MAX_EXT : WID_MAX_STD;
    eff_width = (w > lim) ? lim : w;
  endfunction

  // Serial byte at position pos of a forwarded frame
  function automatic logic [7:0] tx_byte(input logic [28:0] id, input logic ext, input logic inc,
                                         input logic [63:0] data, input logic [3:0] pos);
    logic [3:0]  nid;
    logic [3:0]  di;
    logic [31:0] idw;
    nid = inc ? (ext ? 4'h4 : 4'h2) : 4'h0;
    di  = pos - nid;
    idw = {3'h0, id} >> {(nid - 4'h1 - pos), 3'h0};
    tx_byte = (pos < nid) ? idw[7:0] : data[{di[2:0], 3'h0} +: 8];
  endfunction

  logic [CTRL_W-1:0]  ctrl_r, ctrl_nxt;
  logic [2:0]         pos_r, pos_nxt;
  logic [2:0]         wid_r, wid_nxt;
  logic               trunc_r, trunc_nxt, trunc_set;
  logic               drop_r, drop_nxt, drop_set;
  logic [15:0]        txn_r, txn_nxt;
  logic [15:0]        rxn_r, rxn_nxt;
  logic [DATA_W-1:0]  rdata_r, rdata_nxt;
  logic               f_valid, f_ready;
  logic [FIFO_W-1:0]  f_data;
  ucr_ustate_t        u_state_r, u_state_nxt;
  logic [8:0]         u_idx_r, u_idx_nxt;
  logic [28:0]        u_id_r, u_id_nxt;
  logic [2:0]         u_idcnt_r, u_idcnt_nxt;
  logic [7:0]         u_buf_r [8];
  logic [7:0]         u_buf_nxt [8];
  logic [3:0]         u_cnt_r, u_cnt_nxt;
  logic               u_sent_r, u_sent_nxt;
  logic               u_end_r, u_end_nxt;
  logic               cv_r, cv_nxt;
  logic [28:0]        cid_r, cid_nxt;
  logic               cext_r, cext_nxt;
  logic [3:0]         cdlc_r, cdlc_nxt;
  logic [63:0]        cdat_r, cdat_nxt;
  logic [2:0]         eff_wid;
  logic               in_id;
  logic               c_busy_r, c_busy_nxt;
  logic [3:0]         c_pos_r, c_pos_nxt;
  logic [3:0]         c_len_r, c_len_nxt;
  logic [28:0]        c_id_r, c_id_nxt;
  logic               c_ext_r, c_ext_nxt;
  logic               c_inc_r, c_inc_nxt;
  logic [63:0]        c_data_r, c_data_nxt;
  logic               tv_r, tv_nxt;
  logic [7:0]         td_r, td_nxt;
  logic [3:0]         c_total;
  logic               fail_r, fail_nxt;
  logic               led_r, led_nxt;
  logic [FLASH_W-1:0] fl_cnt_r, fl_cnt_nxt;
  logic [28:0]        prev_id_r;

  // Serial input buffer
  ucr_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_ser_valid),
    .i_in_data   ({i_ser_last, i_ser_data}),
    .o_in_ready  (o_ser_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (f_ready)
  );

  // Register writes, reads and sticky status
  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    pos_nxt   = pos_r;
    wid_nxt   = wid_r;
    rdata_nxt = '0;
    trunc_nxt = trunc_set | (trunc_r & ~(i_wr && i_addr == REG_STATUS && i_wdata[ST_TRUNC]));
    drop_nxt  = drop_set | (drop_r & ~(i_wr && i_addr == REG_STATUS && i_wdata[ST_DROP]));
    txn_nxt   = txn_r + 16'(cv_r && i_can_tx_ready);
    rxn_nxt   = rxn_r + 16'(!c_busy_r && c_busy_nxt);
    if (i_wr)
    begin
      case (i_addr)
        REG_CTRL: ctrl_nxt = i_wdata[CTRL_W-1:0];
        REG_CFG:
        begin
          pos_nxt = i_wdata[POS_LSB +: 3];
          wid_nxt = i_wdata[WID_LSB +: 3];
        end
        default: ;
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        REG_CTRL:   rdata_nxt = {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
        REG_CFG:    rdata_nxt = {25'h0, wid_r, 1'b0, pos_r};
        REG_STATUS: rdata_nxt = {27'h0, c_busy_r, u_state_r == U_SEND, drop_r, trunc_r, fail_r};
        REG_COUNT:  rdata_nxt = {rxn_r, txn_r};
        default:    rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ctrl_r  <= CTRL_RST;
      pos_r   <= POS_RST;
      wid_r   <= WID_RST;
      trunc_r <= 1'b0;
      drop_r  <= 1'b0;
      txn_r   <= '0;
      rxn_r   <= '0;
      rdata_r <= '0;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      pos_r   <= pos_nxt;
      wid_r   <= wid_nxt;
      trunc_r <= trunc_nxt;
      drop_r  <= drop_nxt;
      txn_r   <= txn_nxt;
      rxn_r   <= rxn_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign eff_wid = eff_width(wid_r, ctrl_r[CTRL_EXT_BIT]);
  // Byte lies in the identifier field
  assign in_id   = (eff_wid != 3'h0) && (u_idx_r >= 9'(pos_r)) && (u_idx_r < 9'(pos_r) + 9'(eff_wid));

  // Serial to frame conversion
  always_comb
  begin
    u_state_nxt = u_state_r;
    u_idx_nxt   = u_idx_r;
    u_id_nxt    = u_id_r;
    u_idcnt_nxt = u_idcnt_r;
    u_buf_nxt   = u_buf_r;
    u_cnt_nxt   = u_cnt_r;
    u_sent_nxt  = u_sent_r;
    u_end_nxt   = u_end_r;
    cv_nxt      = cv_r;
    cid_nxt     = cid_r;
    cext_nxt    = cext_r;
    cdlc_nxt    = cdlc_r;
    cdat_nxt    = cdat_r;
    f_ready     = 1'b0;
    trunc_set   = 1'b0;
    case (u_state_r)
      U_COLLECT:
      begin
        f_ready = f_valid;
        if (f_valid && !ctrl_r[CTRL_U2C_BIT])
        begin
          u_idx_nxt   = '0;
          u_id_nxt    = '0;
          u_idcnt_nxt = '0;
          u_cnt_nxt   = '0;
          u_sent_nxt  = 1'b0;
        end
        else if (f_valid)
        begin
          if (u_idx_r >= BLOCK_MAX)
            // Bytes past the block limit dropped
            trunc_set = 1'b1;
          else if (in_id)
          begin
            // Shift in identifier byte, masked to format
            u_id_nxt    = {u_id_r[20:0], f_data[7:0]} & id_mask(ctrl_r[CTRL_EXT_BIT]);
            u_idcnt_nxt = u_idcnt_r + 3'h1;
          end
          else
          begin
            u_buf_nxt[u_cnt_r[2:0]] = f_data[7:0];
            u_cnt_nxt               = u_cnt_r + 4'h1;
          end
          u_idx_nxt = (u_idx_r < BLOCK_MAX) ? u_idx_r + 9'h1 : u_idx_r;
          // Flush on full frame or block end
          if (f_data[8] || u_cnt_nxt == FRAME_MAX)
          begin
            if (u_cnt_nxt != 4'h0 || !u_sent_r)
            begin
              u_state_nxt = U_SEND;
              u_end_nxt   = f_data[8];
              cv_nxt      = 1'b1;
              cid_nxt     = u_id_nxt;
              cext_nxt    = ctrl_r[CTRL_EXT_BIT];
              cdlc_nxt    = u_cnt_nxt;
              for (int k = 0; k < 8; k++)
                cdat_nxt[8*k +: 8] = u_buf_nxt[k];
            end
            else
            begin
              u_idx_nxt   = '0;
              u_id_nxt    = '0;
              u_idcnt_nxt = '0;
              u_sent_nxt  = 1'b0;
            end
          end
        end
      end
      U_SEND:
      begin
        if (i_can_tx_ready)
        begin
          // Same identifier kept until block end
          cv_nxt      = 1'b0;
          u_state_nxt = U_COLLECT;
          u_cnt_nxt   = '0;
          u_sent_nxt  = !u_end_r;
          if (u_end_r)
          begin
            u_idx_nxt   = '0;
            u_id_nxt    = '0;
            u_idcnt_nxt = '0;
          end
        end
      end
      default: u_state_nxt = U_COLLECT;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      u_state_r <= U_COLLECT;
      u_idx_r   <= '0;
      u_id_r    <= '0;
      u_idcnt_r <= '0;
      u_cnt_r   <= '0;
      u_sent_r  <= 1'b0;
      u_end_r   <= 1'b0;
      cv_r      <= 1'b0;
      cid_r     <= '0;
      cext_r    <= 1'b0;
      cdlc_r    <= '0;
      cdat_r    <= '0;
      prev_id_r <= '0;
      for (int k = 0; k < 8; k++)
        u_buf_r[k] <= '0;
    end
    else
    begin
      u_state_r <= u_state_nxt;
      u_idx_r   <= u_idx_nxt;
      u_id_r    <= u_id_nxt;
      u_idcnt_r <= u_idcnt_nxt;
      u_cnt_r   <= u_cnt_nxt;
      u_sent_r  <= u_sent_nxt;
      u_end_r   <= u_end_nxt;
      cv_r      <= cv_nxt;
      cid_r     <= cid_nxt;
      cext_r    <= cext_nxt;
      cdlc_r    <= cdlc_nxt;
      cdat_r    <= cdat_nxt;
      prev_id_r <= (cv_r && i_can_tx_ready) ? cid_r : prev_id_r;
      u_buf_r   <= u_buf_nxt;
    end
  end

  // Serial length: identifier bytes when enabled, then payload
  assign c_total = (ctrl_r[CTRL_IDOUT_BIT] ? (i_can_rx_ext ? 4'h4 : 4'h2) : 4'h0)
                 + ((i_can_rx_dlc > FRAME_MAX) ? FRAME_MAX : i_can_rx_dlc);

  // Frame to serial conversion
  always_comb
  begin
    c_busy_nxt = c_busy_r;
    c_pos_nxt  = c_pos_r;
    c_len_nxt  = c_len_r;
    c_id_nxt   = c_id_r;
    c_ext_nxt  = c_ext_r;
    c_inc_nxt  = c_inc_r;
    c_data_nxt = c_data_r;
    tv_nxt     = tv_r;
    td_nxt     = td_r;
    drop_set   = 1'b0;
    if (!c_busy_r)
    begin
      // Start output the cycle after reception
      if (i_can_rx_valid && ctrl_r[CTRL_C2U_BIT] && c_total != 4'h0)
      begin
        c_busy_nxt = 1'b1;
        c_pos_nxt  = '0;
        c_len_nxt  = c_total;
        c_id_nxt   = i_can_rx_id;
        c_ext_nxt  = i_can_rx_ext;
        c_inc_nxt  = ctrl_r[CTRL_IDOUT_BIT];
        c_data_nxt = i_can_rx_data;
        tv_nxt     = 1'b1;
        td_nxt     = tx_byte(i_can_rx_id, i_can_rx_ext, ctrl_r[CTRL_IDOUT_BIT], i_can_rx_data, 4'h0);
      end
    end
    else
    begin
      drop_set = i_can_rx_valid;
      if (i_tx_ready)
      begin
        if (c_pos_r + 4'h1 == c_len_r)
        begin
          c_busy_nxt = 1'b0;
          tv_nxt     = 1'b0;
        end
        else
        begin
          c_pos_nxt = c_pos_r + 4'h1;
          td_nxt    = tx_byte(c_id_r, c_ext_r, c_inc_r, c_data_r, c_pos_r + 4'h1);
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      c_busy_r <= 1'b0;
      c_pos_r  <= '0;
      c_len_r  <= '0;
      c_id_r   <= '0;
      c_ext_r  <= 1'b0;
      c_inc_r  <= 1'b0;
      c_data_r <= '0;
      tv_r     <= 1'b0;
      td_r     <= '0;
    end
    else
    begin
      c_busy_r <= c_busy_nxt;
      c_pos_r  <= c_pos_nxt;
      c_len_r  <= c_len_nxt;
      c_id_r   <= c_id_nxt;
      c_ext_r  <= c_ext_nxt;
      c_inc_r  <= c_inc_nxt;
      c_data_r <= c_data_nxt;
      tv_r     <= tv_nxt;
      td_r     <= td_nxt;
    end
  end

  // Bus failure flag and indicator flashing
  always_comb
  begin
    fail_nxt   = i_can_tx_err | (fail_r & ~i_can_tx_done);
    led_nxt    = led_r;
    fl_cnt_nxt = fl_cnt_r + 1'b1;
    if (!fail_r)
    begin
      led_nxt    = 1'b1;
      fl_cnt_nxt = '0;
    end
    else if (fl_cnt_r == FLASH_W'(FLASH_HALF - 1))
    begin
      led_nxt    = ~led_r;
      fl_cnt_nxt = '0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      fail_r   <= 1'b0;
      led_r    <= 1'b1;
      fl_cnt_r <= '0;
    end
    else
    begin
      fail_r   <= fail_nxt;
      led_r    <= led_nxt;
      fl_cnt_r <= fl_cnt_nxt;
    end
  end

  // Outputs straight from flops
  assign o_rdata           = rdata_r;
  assign o_tx_valid        = tv_r;
  assign o_tx_data         = td_r;
  assign o_can_tx_valid    = cv_r;
  assign o_can_tx_id       = cid_r;
  assign o_can_tx_ext      = cext_r;
  assign o_can_tx_dlc      = cdlc_r;
  assign o_can_tx_data     = cdat_r;
  assign o_power_indicator = led_r;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_rx_take;
    !c_busy_r && i_can_rx_valid && ctrl_r[CTRL_C2U_BIT] && c_total != 4'h0;
  endsequence
  sequence s_tx_first;
    o_tx_valid && c_pos_r == 4'h0 && c_busy_r;
  endsequence

  a_id_capture: assert property ((f_ready && ctrl_r[CTRL_U2C_BIT] && u_idx_r == 9'(pos_r) && eff_wid != 3'h0) |=> u_idcnt_r == $past(u_idcnt_r) + 3'h1) else $error("id byte not taken");
  a_width_clamp: assert property (eff_wid <= (ctrl_r[CTRL_EXT_BIT] ? WID_MAX_EXT : WID_MAX_STD)) else $error("width above format limit");
  a_id_pad_zero: assert property (o_can_tx_valid |-> ({3'h0, o_can_tx_id} >> {u_idcnt_r, 3'h0}) == 32'h0) else $error("upper id bits not zero");
  a_same_id: assert property ((o_can_tx_valid && u_sent_r) |-> o_can_tx_id == prev_id_r) else $error("identifier changed in block");
  a_frame_len: assert property (o_can_tx_valid |-> o_can_tx_dlc == u_cnt_r && o_can_tx_dlc <= FRAME_MAX) else $error("bad length code");
  a_block_cap: assert property (u_idx_r <= BLOCK_MAX) else $error("block index past limit");
  a_rx_forward: assert property (s_rx_take |=> s_tx_first) else $error("serial output not started");
  a_id_first: assert property ((s_rx_take ##0 ctrl_r[CTRL_IDOUT_BIT]) |=> o_tx_data == (c_ext_r ? {3'h0, c_id_r[28:24]} : c_id_r[15:8])) else $error("first byte not id");
  a_c2u_off: assert property ((!c_busy_r && !ctrl_r[CTRL_C2U_BIT]) |=> !o_tx_valid) else $error("output while disabled");
  a_u2c_off: assert property ((f_ready && !ctrl_r[CTRL_U2C_BIT]) |=> u_cnt_r == 4'h0 && u_idcnt_r == 3'h0) else $error("data kept while disabled");
  a_id_limit: assert property (o_can_tx_valid |-> (o_can_tx_id & ~id_mask(o_can_tx_ext)) == 29'h0) else $error("id over limit");
  a_flash_toggle: assert property ((fail_r && fl_cnt_r == FLASH_W'(FLASH_HALF - 1)) |=> o_power_indicator != $past(o_power_indicator)) else $error("indicator not toggled");
  a_led_steady: assert property (!fail_r |=> o_power_indicator) else $error("indicator off without fault");
endmodule

// file: ucr_can_model.sv
/*
  CAN controller stand-in: takes a frame after a short or long stall,
  then reports it as sent or failed. Assumes frames held until taken.
*/
module ucr_can_model (
  input  wire logic i_clk,   // System clock
  input  wire logic i_valid, // Frame offered
  input  wire logic i_slow,  // Long stall
  input  wire logic i_fail,  // Report failure
  output logic      o_ready, // Frame taken
  output logic      o_done,  // Sent on bus
  output logic      o_err    // Failed on bus
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial
  begin
    o_ready = 0;
    o_done = 0;
    o_err = 0;
  end
  // Takes any identifier within format limit; outcome one cycle after taking
  always @(posedge i_clk)
  begin
    o_ready <= 0;
    o_done <= 0;
    o_err <= 0;
    if (o_ready && i_valid)
    begin
      o_done <= !i_fail;
      o_err <= i_fail;
      cnt <= 0;
    end
    else if (i_valid)
    begin
      cnt <= cnt + 1;
      o_ready <= (cnt >= (i_slow ? 30 : 1));
    end
  end
endmodule

// file: tb.sv
/*
  Relay testbench: table of serial blocks, then direction, reverse path
  and indicator tests. Assumes the CAN model; the bench plays the serial sink.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ucr_pkg::*;
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_ser_valid = 0, i_ser_last = 0, i_can_rx_valid = 0;
  logic slow = 0, fail = 0, full, p, o_ser_ready, o_tx_valid, o_can_tx_valid, o_power_indicator, cr, cd, ce;
  logic trdy = 1, rx_ext = 0, cx;
  logic [3:0] i_addr = 0, o_can_tx_dlc;
  logic [31:0] i_wdata = 0, o_rdata;
  logic [7:0] i_ser_data = 0, o_tx_data, txq[$], pay[$];
  logic [28:0] o_can_tx_id, id, fid[$], rx_id = 29'h123;
  logic [3:0] fdl[$];
  logic [63:0] o_can_tx_data, fdt[$];
  int errors = 0, cmp_count = 0, cyc = 0, k, w, nf, tog;
  int pos_t[8] = '{0, 1, 7, 0, 2, 0, 0, 3}, wid_t[8] = '{1, 2, 2, 3, 4, 1, 1, 0};
  int n_t[8] = '{2, 12, 9, 3, 5, 40, 260, 10};
  bit ext_t[8] = '{0, 0, 0, 1, 0, 0, 0, 0}, slow_t[8] = '{0, 0, 0, 0, 0, 1, 0, 0}, fex[$];
  ucr_relay #(.FLASH_HALF(8)) dut_u (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_ser_valid, .i_ser_data, .i_ser_last, .o_ser_ready, .o_tx_valid, .o_tx_data, .i_tx_ready(trdy),
    .o_can_tx_valid, .o_can_tx_id, .o_can_tx_ext(cx), .o_can_tx_dlc, .o_can_tx_data, .i_can_tx_ready(cr),
    .i_can_tx_done(cd), .i_can_tx_err(ce), .i_can_rx_valid, .i_can_rx_id(rx_id), .i_can_rx_ext(rx_ext),
    .i_can_rx_dlc(4'h1), .i_can_rx_data(64'h55), .o_power_indicator);
  ucr_can_model can_u (.i_clk, .i_valid(o_can_tx_valid), .i_slow(slow), .i_fail(fail), .o_ready(cr),
    .o_done(cd), .o_err(ce));
  always #5 i_clk = ~i_clk;
  // Timeout, frame and serial byte monitors
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      close_out;
    end
    if (o_can_tx_valid && cr)
    begin
      fid.push_back(o_can_tx_id);
      fdl.push_back(o_can_tx_dlc);
      fdt.push_back(o_can_tx_data);
      fex.push_back(cx);
    end
    if (o_tx_valid && trdy) txq.push_back(o_tx_data);
  end
  task chk(string n, logic [63:0] e, logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [3:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a; i_wdata <= d; i_wr <= 1;
    @(posedge i_clk);
    i_wr <= 0;
  endtask
  task rd(logic [3:0] a, logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a; i_rd <= 1;
    @(posedge i_clk);
    i_rd <= 0;
    #1 chk("rdata", e, o_rdata);
  endtask
  // Bytes 1..n, each held until the FIFO takes it
  task send(int n);
    @(posedge i_clk);
    for (int i = 0; i < n; i++)
    begin
      i_ser_valid <= 1; i_ser_data <= 8'(i + 1); i_ser_last <= (i == n - 1);
      @(negedge i_clk);
      while (!o_ser_ready)
      begin
        full = 1;
        @(negedge i_clk);
      end
      @(posedge i_clk);
    end
    i_ser_valid <= 0;
  endtask
  task rxf;
    @(posedge i_clk);
    i_can_rx_valid <= 1;
    @(posedge i_clk);
    i_can_rx_valid <= 0;
  endtask
  task count_tog;
    tog = 0;
    for (k = 0; k < 32; k++)
    begin
      p = o_power_indicator;
      @(posedge i_clk);
      #1 if (o_power_indicator !== p) tog++;
    end
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst <= 0;
    #1 chk("led_rst", 1, o_power_indicator);
    rd(REG_CTRL, 32'h3);
    rd(REG_CFG, 32'h10);
    wr(4'hf, 32'hffff);
    rd(4'hf, 32'h0);
    for (int r = 0; r < 8; r++)
    begin
      wr(REG_CTRL, {29'h0, ext_t[r], 2'b11});
      wr(REG_CFG, 32'(wid_t[r] * 16 + pos_t[r]));
      slow <= slow_t[r]; full = 0; id = 0;
      fid.delete(); fdl.delete(); fdt.delete(); fex.delete(); pay.delete();
      w = (wid_t[r] > (ext_t[r] ? 4 : 2)) ? (ext_t[r] ? 4 : 2) : wid_t[r];
      for (int i = 0; i < n_t[r] && i < BLOCK_MAX; i++)
        if (i >= pos_t[r] && i < pos_t[r] + w) id = {id[20:0], 8'(i + 1)};
        else pay.push_back(8'(i + 1));
      id = id & (ext_t[r] ? ID_MASK_EXT : ID_MASK_STD);
      nf = (pay.size() == 0) ? 1 : (pay.size() + 7) / 8;
      send(n_t[r]);
      for (k = 0; k < 600 && fdl.size() < nf; k++) @(posedge i_clk);
      chk("frames", nf, fdl.size());
      for (int f = 0; f < fdl.size() && f < nf; f++)
      begin
        chk("id", id, fid[f]);
        chk("ext", ext_t[r], fex[f]);
        chk("dlc", (pay.size() - 8 * f > 8) ? 8 : pay.size() - 8 * f, fdl[f]);
        for (int b = 0; b < fdl[f]; b++) chk("byte", pay[8 * f + b], fdt[f][8 * b +: 8]);
      end
      if (slow_t[r]) chk("fifo_full", 1, full);
      $display("test row %0d done", r);
    end
    wr(REG_CTRL, 32'h0);
    fid.delete(); txq.delete();
    send(3);
    rxf;
    repeat (30) @(posedge i_clk);
    chk("off_frames", 0, fid.size());
    chk("off_bytes", 0, txq.size());
    wr(REG_CTRL, 32'hb);
    rxf;
    #1 chk("tx_soon", 1, o_tx_valid);
    for (k = 0; k < 50 && txq.size() < 3; k++) @(posedge i_clk);
    chk("tx_bytes", 24'h012355, {txq[0], txq[1], txq[2]});
    txq.delete();
    trdy <= 0; rx_ext <= 1; rx_id <= 29'h12345678;
    rxf;
    rxf;
    trdy <= 1;
    for (k = 0; k < 50 && txq.size() < 5; k++) @(posedge i_clk);
    chk("tx_ext", 40'h1234567855, {txq[0], txq[1], txq[2], txq[3], txq[4]});
    rd(REG_STATUS, 32'h6);
    wr(REG_STATUS, 32'h6);
    rd(REG_STATUS, 32'h0);
    $display("test direction and reverse done");
    fail <= 1;
    send(2);
    repeat (20) @(posedge i_clk);
    count_tog;
    chk("toggles", 4, tog);
    fail <= 0;
    send(2);
    repeat (20) @(posedge i_clk);
    count_tog;
    chk("steady", 0, tog);
    chk("led", 1, o_power_indicator);
    $display("test indicator done");
    i_rst <= 1;
    repeat (2) @(posedge i_clk);
    i_rst <= 0;
    rd(REG_CTRL, 32'h3);
    rd(REG_CFG, 32'h10);
    $display("test reset done");
    close_out;
  end
endmodule
